// File: common/acs_pkg.sv
package acs_pkg;

    // ****************************************************************
    // register map (byte offsets on the plain register port)
    // ****************************************************************
    localparam logic [3:0] OFF_SC1 = 4'h0;
    localparam logic [3:0] OFF_SC2 = 4'h1;
    localparam logic [3:0] OFF_RES_HIGH = 4'h2;
    localparam logic [3:0] OFF_RES_LOW = 4'h3;
    localparam logic [3:0] OFF_CMP_HIGH = 4'h4;
    localparam logic [3:0] OFF_CMP_LOW = 4'h5;
    localparam logic [3:0] OFF_CFG = 4'h6;
    localparam logic [3:0] OFF_PIN_UPPER = 4'h7;
    localparam logic [3:0] OFF_SAR_DATA = 4'h8;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE = 6;
    localparam int SC1_CONTINUOUS_ENABLE = 5;
    localparam int SC2_ACT = 7;
    localparam int SC2_TRG = 6;
    localparam int SC2_CFE = 5;
    localparam int SC2_CFGT = 4;

    // ****************************************************************
    // reset values and encodings
    // ****************************************************************
    localparam logic [4:0] CHAN_OFF = 5'h1f;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;

    // ****************************************************************
    // timing counts in converter clock ticks
    // ****************************************************************
    localparam logic [5:0] SAMPLE_SHORT = 6'h03;
    localparam logic [5:0] SAMPLE_LONG = 6'h17;
    localparam logic [5:0] STEPS_10BIT = 6'h0b;
    localparam logic [5:0] STEPS_8BIT = 6'h09;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_DONE = 2'b11
    } acs_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_type;

    typedef struct packed {
        logic [7:0] pin_off;
        logic [7:0] out_enable_n;
        logic [7:0] in_enable;
        logic [7:0] pullup_enable;
    } acs_pin_ctl_type;

endpackage : acs_pkg

// File: core/acs_clkdiv.sv
`timescale 1ns/1ps
// converter clock enable: source select then 1/2/4/8 divide
module acs_clkdiv (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    input wire logic [1:0] src_sel,
    input wire logic [1:0] div_sel,
    input wire logic alt_tick,
    input wire logic async_tick,
    output logic conv_tick
);
    typedef struct packed {
        logic half;
        logic [2:0] cnt;
    } acs_div_state_type;

    acs_div_state_type s_q, s_d;
    logic src_tick;
    logic [2:0] limit;

    always_comb begin
        unique case (src_sel)
            acs_pkg::CLK_BUS: src_tick = 1'b1;
            acs_pkg::CLK_BUS_HALF: src_tick = s_q.half;
            acs_pkg::CLK_ALT: src_tick = alt_tick;
            acs_pkg::CLK_ASYNC: src_tick = async_tick;
        endcase
        limit = 3'((4'h1 << div_sel) - 4'h1);
        s_d = s_q;
        s_d.half = ~s_q.half;
        conv_tick = 1'b0;
        if (!run) begin
            s_d.cnt = 3'h0;
        end else if (src_tick) begin
            if (s_q.cnt >= limit) begin
                s_d.cnt = 3'h0;
                conv_tick = 1'b1;
            end else begin
                s_d.cnt = 3'(s_q.cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : acs_clkdiv

// File: core/acs_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - converter off during reset and while channel_select is all ones
// - return to lowest-power idle after a finished conversion
// - successive approximation yields 11 bits (10-bit) or 9 bits (8-bit)
// - round to 10 bits into both result registers, or 8 into low
// - set complete flag on transfer; interrupt if enable high
// - compare_enable checks every result against compare registers
// - four clock sources, bus clock after reset
// - select 00 bus, 01 bus/2, 10 alternate, 11 async clock
// - halved bus clock with divide by 8 gives divide by 16
// - async clock taken from the async_tick input, runs in wait and stop3
// - clock_divide gives ratios 1, 2, 4 or 8
// - upper pin-disable bits 7..0 map channels 23..16
// - disabled pin: output high-z, input and pullup off, reads zero
// - hardware trigger select starts conversion on trigger rising edge
// - trigger edge ignored while a conversion runs
// - continuous hardware mode obeys only the first edge
// - software mode: write of control one with channel not all ones starts
// - continuous mode restarts after each transfer until aborted
// - 10-bit: high read, low unread blocks transfer, flag stays clear
// - after block restart, unless single compare with false condition
// - 8-bit and 10-bit modes, software or hardware trigger each
// - writes to control, config, compare registers, reset, stop abort
// - compare: greater-or-equal when select is 1, below when 0
module acs_sequencer (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire acs_pkg::acs_bus_req_type bus_req,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic hw_trigger_input,
    input wire logic alt_tick,
    input wire logic async_tick,
    input wire logic stop_mode,
    input wire logic sar_comp,
    output logic [10:0] sar_trial,
    output logic sar_sample,
    output logic conv_active,
    output logic [4:0] chan_sel,
    output acs_pkg::acs_pin_ctl_type pin_ctl
);
    typedef struct packed {
        logic [4:0] chan;
        logic conversion_complete_flag;
        logic complete_irq_enable;
        logic continuous_enable;
        logic trg;
        logic cfe;
        logic cfgt;
        logic [7:0] cfg;
        logic [7:0] pins;
        logic [9:0] cmp;
        logic [9:0] res;
        logic rd_block;
        logic [1:0] trg_sync;
        logic trg_prev;
        logic seq_armed;
        acs_pkg::acs_state_type st;
        logic [5:0] cnt;
        logic [10:0] sar;
        logic [3:0] bitpos;
        logic [7:0] rdata;
        logic irq;
    } acs_state_all_type;

    acs_state_all_type s_q, s_d;
    logic conv_tick;
    logic ten_bit;
    logic [9:0] rounded;
    logic [10:0] diff;
    logic cmp_ok;
    logic wr_sc1, wr_abort, trg_rise, start, blocked, sw_start, halt;

    acs_clkdiv u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(s_q.st != acs_pkg::ST_IDLE),
        .src_sel(s_q.cfg[1:0]),
        .div_sel(s_q.cfg[6:5]),
        .alt_tick(alt_tick),
        .async_tick(async_tick),
        .conv_tick(conv_tick)
    );

    // ****************************************************************
    // datapath
    // ****************************************************************
    always_comb begin
        ten_bit = (s_q.cfg[3:2] == acs_pkg::MODE_10BIT);
        // rounding: add half an lsb, saturate at full scale
        if (ten_bit) begin
            rounded = (s_q.sar[10:1] == 10'h3ff) ? 10'h3ff
                : 10'(s_q.sar[10:1] + {9'h000, s_q.sar[0]});
        end else begin
            rounded = (s_q.sar[10:3] == 8'hff) ? 10'h0ff
                : {2'h0, 8'(s_q.sar[10:3] + {7'h00, s_q.sar[2]})};
        end
        // result plus two's complement of compare value
        diff = 11'({1'b0, rounded} + {1'b0, ~s_q.cmp} + 11'h001);
        cmp_ok = s_q.cfgt ? diff[10] : ~diff[10];
    end

    // ****************************************************************
    // control
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        wr_sc1 = bus_req.wr && bus_req.addr == acs_pkg::OFF_SC1;
        wr_abort = bus_req.wr && (bus_req.addr == acs_pkg::OFF_SC2
            || bus_req.addr == acs_pkg::OFF_CFG
            || bus_req.addr == acs_pkg::OFF_CMP_HIGH
            || bus_req.addr == acs_pkg::OFF_CMP_LOW);
        halt = wr_sc1 || wr_abort
            || (stop_mode && s_q.cfg[1:0] != acs_pkg::CLK_ASYNC);
        // only the second stage feeds the edge detector
        s_d.trg_sync = {s_q.trg_sync[0], hw_trigger_input};
        s_d.trg_prev = s_q.trg_sync[1];
        trg_rise = s_q.trg_sync[1] & ~s_q.trg_prev;
        start = 1'b0;
        sw_start = 1'b0;
        blocked = 1'b0;
        s_d.irq = 1'b0;
        s_d.rdata = 8'h00;

        // register reads and their side effects
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                acs_pkg::OFF_SC1: s_d.rdata = {s_q.conversion_complete_flag, s_q.complete_irq_enable,
                    s_q.continuous_enable, s_q.chan};
                acs_pkg::OFF_SC2: s_d.rdata = {
                    s_q.st != acs_pkg::ST_IDLE, s_q.trg, s_q.cfe,
                    s_q.cfgt, 4'h0};
                acs_pkg::OFF_RES_HIGH: begin
                    s_d.rdata = {6'h00, s_q.res[9:8]};
                    s_d.rd_block = ten_bit;
                end
                acs_pkg::OFF_RES_LOW: begin
                    s_d.rdata = s_q.res[7:0];
                    s_d.rd_block = 1'b0;
                    s_d.conversion_complete_flag = 1'b0;
                end
                acs_pkg::OFF_CMP_HIGH: s_d.rdata = {6'h00, s_q.cmp[9:8]};
                acs_pkg::OFF_CMP_LOW: s_d.rdata = s_q.cmp[7:0];
                acs_pkg::OFF_CFG: s_d.rdata = s_q.cfg;
                acs_pkg::OFF_PIN_UPPER: s_d.rdata = s_q.pins;
                default: s_d.rdata = 8'h00;
            endcase
        end

        // register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                acs_pkg::OFF_SC1: begin
                    s_d.complete_irq_enable = bus_req.wdata[acs_pkg::SC1_COMPLETE_IRQ_ENABLE];
                    s_d.continuous_enable = bus_req.wdata[acs_pkg::SC1_CONTINUOUS_ENABLE];
                    s_d.chan = bus_req.wdata[4:0];
                    s_d.conversion_complete_flag = 1'b0;
                end
                acs_pkg::OFF_SC2: begin
                    s_d.trg = bus_req.wdata[acs_pkg::SC2_TRG];
                    s_d.cfe = bus_req.wdata[acs_pkg::SC2_CFE];
                    s_d.cfgt = bus_req.wdata[acs_pkg::SC2_CFGT];
                end
                acs_pkg::OFF_CMP_HIGH: s_d.cmp[9:8] = bus_req.wdata[1:0];
                acs_pkg::OFF_CMP_LOW: s_d.cmp[7:0] = bus_req.wdata;
                acs_pkg::OFF_CFG: s_d.cfg = bus_req.wdata;
                acs_pkg::OFF_PIN_UPPER: s_d.pins = bus_req.wdata;
                default: ;
            endcase
        end

        // trigger decision
        if (wr_sc1 && bus_req.wdata[4:0] != acs_pkg::CHAN_OFF
            && !s_q.trg) begin
            start = 1'b1;
            sw_start = 1'b1;
        end
        if (s_q.trg && trg_rise && s_q.st == acs_pkg::ST_IDLE
            && !s_q.seq_armed && s_q.chan != acs_pkg::CHAN_OFF) begin
            start = 1'b1;
        end

        // conversion state machine
        unique case (s_q.st)
            acs_pkg::ST_IDLE: ;
            acs_pkg::ST_SAMPLE: begin
                if (conv_tick) begin
                    if (s_q.cnt == 6'h00) begin
                        s_d.st = acs_pkg::ST_CONVERT;
                        s_d.bitpos = 4'ha;
                        s_d.sar = 11'h400;
                    end else begin
                        s_d.cnt = 6'(s_q.cnt - 6'h01);
                    end
                end
            end
            acs_pkg::ST_CONVERT: begin
                if (conv_tick) begin
                    if (!sar_comp) begin
                        s_d.sar[s_q.bitpos] = 1'b0;
                    end
                    if (s_q.bitpos == (ten_bit ? 4'h0 : 4'h2)) begin
                        s_d.st = acs_pkg::ST_DONE;
                    end else begin
                        s_d.bitpos = 4'(s_q.bitpos - 4'h1);
                        s_d.sar[s_q.bitpos - 4'h1] = 1'b1;
                    end
                end
            end
            acs_pkg::ST_DONE: begin
                s_d.st = acs_pkg::ST_IDLE;
                blocked = ten_bit && s_q.rd_block;
                if (s_q.cfe && !cmp_ok) begin
                    // single compare miss ends here even when blocked
                    if (s_q.continuous_enable) begin
                        start = 1'b1;
                    end
                end else if (blocked) begin
                    start = 1'b1;
                end else begin
                    s_d.res = s_q.cfe ? diff[9:0] : rounded;
                    s_d.conversion_complete_flag = 1'b1;
                    s_d.irq = s_q.complete_irq_enable;
                    if (s_q.continuous_enable) begin
                        start = 1'b1;
                    end
                end
                if (s_q.continuous_enable || blocked) begin
                    s_d.seq_armed = s_q.trg;
                end
            end
            default: s_d.st = acs_pkg::ST_IDLE;
        endcase

        // an abort beats any restart except the write's own start
        if (start && (sw_start || !halt)) begin
            s_d.st = acs_pkg::ST_SAMPLE;
            s_d.cnt = s_q.cfg[4] ? acs_pkg::SAMPLE_LONG
                : acs_pkg::SAMPLE_SHORT;
            s_d.seq_armed = s_q.continuous_enable || s_q.trg;
        end else if (halt) begin
            s_d.st = acs_pkg::ST_IDLE;
            s_d.seq_armed = 1'b0;
        end
        if (s_d.st == acs_pkg::ST_IDLE && !start) begin
            s_d.seq_armed = 1'b0;
        end
        if (wr_sc1 && bus_req.wdata[4:0] == acs_pkg::CHAN_OFF) begin
            s_d.st = acs_pkg::ST_IDLE;
            s_d.seq_armed = 1'b0;
        end
        if (wr_sc1 && s_q.st == acs_pkg::ST_DONE
            && s_d.conversion_complete_flag && !s_q.conversion_complete_flag) begin
            s_d.conversion_complete_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.chan <= acs_pkg::CHAN_OFF;
            s_q.cfg <= acs_pkg::CFG_RESET;
            s_q.pins <= acs_pkg::PIN_RESET;
            s_q.st <= acs_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            always_comb begin
                pin_ctl.pin_off[gi] = s_q.pins[gi];
                pin_ctl.out_enable_n[gi] = s_q.pins[gi];
                pin_ctl.in_enable[gi] = ~s_q.pins[gi];
                pin_ctl.pullup_enable[gi] = ~s_q.pins[gi];
            end
        end
    endgenerate

    assign rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign sar_trial = s_q.sar;
    assign sar_sample = (s_q.st == acs_pkg::ST_SAMPLE);
    assign conv_active = (s_q.st != acs_pkg::ST_IDLE);
    assign chan_sel = s_q.chan;
endmodule : acs_sequencer

// File: verif/acs_seq_props.sv
`timescale 1ns/1ps
// ********
// sequencer port checks
// ********
module acs_seq_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire acs_pkg::acs_bus_req_type bus_req,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic hw_trigger_input,
    input wire logic stop_mode,
    input wire logic sar_sample,
    input wire logic conv_active,
    input wire logic [4:0] chan_sel,
    input wire acs_pkg::acs_pin_ctl_type pin_ctl
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic hw_q;
    logic [1:0] src_q;
    logic wr_sc1;
    logic wr_abort;
    assign wr_sc1 = bus_req.wr && bus_req.addr == acs_pkg::OFF_SC1;
    assign wr_abort = bus_req.wr && bus_req.addr inside {acs_pkg::OFF_SC2,
        acs_pkg::OFF_CFG, acs_pkg::OFF_CMP_HIGH, acs_pkg::OFF_CMP_LOW};
    // shadows of trigger and clock select, rebuilt from port writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hw_q <= 1'b0;
            src_q <= acs_pkg::CLK_BUS;
        end else if (bus_req.wr) begin
            if (bus_req.addr == acs_pkg::OFF_SC2) begin
                hw_q <= bus_req.wdata[acs_pkg::SC2_TRG];
            end
            if (bus_req.addr == acs_pkg::OFF_CFG) begin
                src_q <= bus_req.wdata[1:0];
            end
        end
    end
    pin_hiz_a: assert property (
        (pin_ctl.pin_off & ~pin_ctl.out_enable_n) == 8'h00)
        else $error("disabled pin still driven");
    pin_bufs_a: assert property (
        (pin_ctl.pin_off & (pin_ctl.in_enable | pin_ctl.pullup_enable))
        == 8'h00) else $error("disabled pin buffer or pullup on");
    chan_off_a: assert property (
        (chan_sel == acs_pkg::CHAN_OFF)[*2] |-> !conv_active)
        else $error("converter active with channel off");
    idle_quiet_a: assert property (!conv_active |-> !sar_sample)
        else $error("sampling while idle");
    irq_pulse_a: assert property (irq |=> !irq)
        else $error("irq longer than one cycle");
    irq_cause_a: assert property (irq |-> $past(conv_active))
        else $error("irq without a conversion");
    sw_start_a: assert property (
        wr_sc1 && !hw_q && bus_req.wdata[4:0] != acs_pkg::CHAN_OFF
        |=> conv_active && sar_sample) else $error("write did not start");
    hw_nostart_a: assert property (wr_sc1 && hw_q |=> !conv_active)
        else $error("write started in trigger mode");
    cfg_abort_a: assert property (wr_abort |=> !conv_active)
        else $error("write did not abort");
    stop_abort_a: assert property (
        $rose(stop_mode) && src_q != acs_pkg::CLK_ASYNC |=> !conv_active)
        else $error("stop did not abort");
    trig_start_a: assert property (
        $rose(hw_trigger_input) && hw_q && !conv_active && !bus_req.wr
        |=> !conv_active ##[1:3] conv_active)
        else $error("trigger start timing wrong");
    cover property (wr_sc1 ##1 conv_active);
    cover property ($rose(hw_trigger_input) && conv_active);
    cover property (irq ##[1:40] irq);
endmodule : acs_seq_props

// File: verif/acs_analog_model.sv
`timescale 1ns/1ps
// ********
// analog side and free-running clock stand-ins
// ********
module acs_analog_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [10:0] vin,
    input wire logic [10:0] sar_trial,
    output logic sar_comp,
    output logic alt_tick,
    output logic async_tick
);
    logic [2:0] alt_cnt;
    logic [2:0] asy_cnt;
    assign sar_comp = (vin >= sar_trial);
    // odd periods so source mix-ups change the conversion time
    assign alt_tick = (alt_cnt == 3'h0);
    assign async_tick = (asy_cnt == 3'h0);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alt_cnt <= 3'h0;
            asy_cnt <= 3'h0;
        end else begin
            alt_cnt <= (alt_cnt == 3'h2) ? 3'h0 : alt_cnt + 3'h1;
            asy_cnt <= (asy_cnt == 3'h4) ? 3'h0 : asy_cnt + 3'h1;
        end
    end
endmodule : acs_analog_model

// File: verif/acs_sequencer_tb.sv
`timescale 1ns/1ps
// ********
// bench
// ********
module acs_sequencer_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    acs_pkg::acs_bus_req_type bus_req = '0;
    logic hw_trigger_input = 1'b0;
    logic stop_mode = 1'b0;
    logic [10:0] vin = 11'h000;
    logic [7:0] rdata;
    logic irq, sar_comp, alt_tick, async_tick, sar_sample, conv_active;
    logic [10:0] sar_trial;
    logic [4:0] chan_sel;
    acs_pkg::acs_pin_ctl_type pin_ctl;
    int mismatches = 0;
    int comparisons = 0;
    int irqs = 0;
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000_f78a;
    logic [7:0] exp_q[$];
    string name_q[$];
    acs_sequencer dut (.clk_sys(clk_sys), .resetn(resetn),
        .bus_req(bus_req), .rdata(rdata), .irq(irq),
        .hw_trigger_input(hw_trigger_input), .alt_tick(alt_tick),
        .async_tick(async_tick), .stop_mode(stop_mode),
        .sar_comp(sar_comp), .sar_trial(sar_trial),
        .sar_sample(sar_sample), .conv_active(conv_active),
        .chan_sel(chan_sel), .pin_ctl(pin_ctl));
    acs_analog_model model (.clk_sys(clk_sys), .resetn(resetn), .vin(vin),
        .sar_trial(sar_trial), .sar_comp(sar_comp), .alt_tick(alt_tick),
        .async_tick(async_tick));
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic check(input string n, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, string n);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        exp_q.push_back(e);
        name_q.push_back(n);
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
    endtask : rd
    task automatic wait_irq(output int n);
        int k;
        k = irqs;
        n = 0;
        while (irqs == k && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000) mismatches++;
    endtask : wait_irq
    task automatic pulse_trig;
        @(posedge clk_sys);
        hw_trigger_input <= 1'b1;
        repeat (4) @(posedge clk_sys);
        hw_trigger_input <= 1'b0;
    endtask : pulse_trig
    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_seen <= bus_req.rd;
        if (rd_seen) check(name_q.pop_front(), {8'h00, rdata},
            {8'h00, exp_q.pop_front()});
        if (irq === 1'b1) irqs++;
    end
    initial begin
        #1_000_000;
        mismatches++;
        end_sim();
    end
    initial begin
        int n, k, p;
        logic [7:0] r, cfg;
        logic [10:0] v1;
        int src_t[8] = '{0, 0, 0, 0, 1, 2, 3, 1};
        int div_t[8] = '{0, 1, 2, 3, 0, 0, 0, 3};
        int per_t[8] = '{1, 2, 4, 8, 2, 3, 5, 16};
        logic [7:0] csc[4] = '{8'h30, 8'h30, 8'h20, 8'h20};
        logic [9:0] ccv[4] = '{10'h201, 10'h1fb, 10'h203, 10'h1ff};
        logic [9:0] cres[4] = '{10'h000, 10'h005, 10'h3fd, 10'h000};
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(acs_pkg::OFF_SC1, 8'h1f, "sc1");
        rd(acs_pkg::OFF_CFG, 8'h00, "cfg");
        rd(acs_pkg::OFF_PIN_UPPER, 8'h00, "pin");
        rd(4'hf, 8'h00, "unmapped");
        seed = xs(seed);
        r = seed[7:0];
        wr(acs_pkg::OFF_PIN_UPPER, r);
        rd(acs_pkg::OFF_PIN_UPPER, r, "pin");
        check("pin_off", {8'h00, pin_ctl.pin_off}, {8'h00, r});
        // results read only after completion
        for (int i = 0; i < 8; i++) begin
            p = per_t[i];
            cfg = 8'h08 | 8'(div_t[i] * 32) | 8'(src_t[i]);
            seed = xs(seed);
            vin <= {seed[9:0], 1'b0};
            wr(acs_pkg::OFF_CFG, cfg);
            wr(acs_pkg::OFF_SC1, 8'h43);
            wait_irq(n);
            check("conv_time", {15'h0000, n >= 14 * p && n <= 16 * p + 8},
                16'h0001);
            rd(acs_pkg::OFF_SC1, 8'hc3, "sc1");
            rd(acs_pkg::OFF_RES_HIGH, {6'h00, vin[10:9]}, "res_high");
            rd(acs_pkg::OFF_RES_LOW, vin[8:1], "res_low");
        end
        vin <= {r, 3'h0};
        wr(acs_pkg::OFF_CFG, 8'h00);
        wr(acs_pkg::OFF_SC1, 8'h45);
        wait_irq(n);
        rd(acs_pkg::OFF_RES_LOW, r, "res8");
        vin <= 11'h400;
        wr(acs_pkg::OFF_CFG, 8'h08);
        for (int j = 0; j < 4; j++) begin
            wr(acs_pkg::OFF_SC2, csc[j]);
            wr(acs_pkg::OFF_CMP_HIGH, {6'h00, ccv[j][9:8]});
            wr(acs_pkg::OFF_CMP_LOW, ccv[j][7:0]);
            k = irqs;
            wr(acs_pkg::OFF_SC1, 8'h46);
            repeat (60) @(negedge clk_sys);
            check("cmp_fire", 16'(irqs - k),
                {15'h0000, cres[j] != 10'h000});
            check("cmp_idle", {15'h0000, conv_active}, 16'h0000);
            if (cres[j] != 10'h000)
                rd(acs_pkg::OFF_RES_LOW, cres[j][7:0], "cmp_res");
        end
        wr(acs_pkg::OFF_SC2, 8'h00);
        seed = xs(seed);
        v1 = {seed[9:0], 1'b0};
        vin <= v1;
        wr(acs_pkg::OFF_SC1, 8'h67);
        wait_irq(n);
        rd(acs_pkg::OFF_RES_HIGH, {6'h00, v1[10:9]}, "res_high");
        vin <= v1 ^ 11'h2aa;
        k = irqs;
        repeat (200) @(negedge clk_sys);
        check("blocked", 16'(irqs - k), 16'h0000);
        rd(acs_pkg::OFF_RES_LOW, v1[8:1], "res_low");
        wait_irq(n);
        check("resume", {15'h0000, n <= 40}, 16'h0001);
        v1 = v1 ^ 11'h2aa;
        rd(acs_pkg::OFF_RES_HIGH, {6'h00, v1[10:9]}, "res_high");
        rd(acs_pkg::OFF_RES_LOW, v1[8:1], "res_low");
        wr(acs_pkg::OFF_SC2, 8'h00);
        // a transfer at the abort edge itself is legal
        repeat (2) @(negedge clk_sys);
        k = irqs;
        repeat (100) @(negedge clk_sys);
        check("aborted", 16'(irqs - k), 16'h0000);
        wr(acs_pkg::OFF_SC2, 8'h40);
        wr(acs_pkg::OFF_SC1, 8'h48);
        k = irqs;
        pulse_trig();
        repeat (2) @(posedge clk_sys);
        pulse_trig();
        repeat (100) @(negedge clk_sys);
        check("trig_count", 16'(irqs - k), 16'h0001);
        wr(acs_pkg::OFF_SC1, 8'h68);
        k = irqs;
        pulse_trig();
        repeat (40) @(negedge clk_sys);
        pulse_trig();
        repeat (100) @(negedge clk_sys);
        check("hw_cont", 16'(irqs - k >= 5), 16'h0001);
        wr(acs_pkg::OFF_SC2, 8'h00);
        wr(acs_pkg::OFF_SC1, 8'h49);
        repeat (5) @(posedge clk_sys);
        stop_mode <= 1'b1;
        k = irqs;
        repeat (60) @(posedge clk_sys);
        stop_mode <= 1'b0;
        check("stop_abort", 16'(irqs - k), 16'h0000);
        wr(acs_pkg::OFF_CFG, 8'h0b);
        wr(acs_pkg::OFF_SC1, 8'h49);
        stop_mode <= 1'b1;
        wait_irq(n);
        stop_mode <= 1'b0;
        check("stop_async", 16'(n < 200), 16'h0001);
        wr(acs_pkg::OFF_SC1, 8'h1f);
        repeat (40) @(negedge clk_sys);
        check("chan_off", {15'h0000, conv_active}, 16'h0000);
        rd(acs_pkg::OFF_SC1, 8'h1f, "sc1");
        repeat (4) @(posedge clk_sys);
        end_sim();
    end
endmodule : acs_sequencer_tb
bind acs_sequencer acs_seq_props u_props (.clk_sys(clk_sys),
    .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .irq(irq),
    .hw_trigger_input(hw_trigger_input), .stop_mode(stop_mode),
    .sar_sample(sar_sample), .conv_active(conv_active),
    .chan_sel(chan_sel), .pin_ctl(pin_ctl));
